// ### hw/gcfr_cfg.svh
// Offsets, field positions, codes and timing constants of the command block
`ifndef GCFR_CFG_SVH
`define GCFR_CFG_SVH

// Byte indices, command and status maps alike
`define GCFR_CMD_OFS      3'h0
`define GCFR_RSV_A_OFS    3'h1
`define GCFR_RSV_B_OFS    3'h2
`define GCFR_POS_OFS      3'h3
`define GCFR_SPEED_OFS    3'h4
`define GCFR_FORCE_OFS    3'h5
`define GCFR_LAST_OFS     3'h5

// Command byte bit positions
`define GCFR_ACT_BIT      0
`define GCFR_GOTO_BIT     3
`define GCFR_ATR_BIT      4
`define GCFR_ARD_BIT      5

// Reset values
`define GCFR_BYTE_RST     8'h00

// Gripper-side codes
`define GCFR_G_NONE       4'h0
`define GCFR_G_NOT_READY  4'h5
`define GCFR_G_NOT_ACT    4'h7
`define GCFR_G_RELEASING  4'hb
`define GCFR_G_OVERCUR    4'he
`define GCFR_G_REL_DONE   4'hf

// Controller-side codes
`define GCFR_K_NONE       4'h0
`define GCFR_K_NO_24V     4'h4
`define GCFR_K_NO_DEV     4'h5
`define GCFR_K_COMM_WAIT  4'h9
`define GCFR_K_ESTOP      4'hc
`define GCFR_K_OVERCUR    4'he

// Fault light blink half period
`define GCFR_BLINK_MS     250
`define GCFR_CLK_KHZ      25000
`define GCFR_BLINK_CYC    (`GCFR_BLINK_MS * `GCFR_CLK_KHZ)

`endif

// ### hw/gcfr_pkg.sv
// Types shared by the command and fault register block
package gcfr_pkg;

	typedef enum logic [1:0] {
		GCFR_RESET   = 2'b00,
		GCFR_INIT    = 2'b01,
		GCFR_READY   = 2'b10,
		GCFR_RELDONE = 2'b11
	} gcfr_mode_type;

	// Write strobe with byte index and data
	typedef struct packed {
		logic       wr;
		logic [2:0] addr;
		logic [7:0] data;
	} gcfr_wr_type;

	// Commands handed to the motion engine
	typedef struct packed {
		logic       goto_en;
		logic       release_en;
		logic       release_dir;
		logic [7:0] target;
		logic [7:0] speed;
		logic [7:0] force_lim;
		logic       force_mask;
	} gcfr_motion_type;

	// Events reported by the motion engine and controller
	typedef struct packed {
		logic init_done;
		logic release_done;
		logic grip_overcur;
		logic ctrl_overcur;
		logic estop;
		logic no_24v;
		logic no_device;
		logic comm_wait;
		logic near_start;
	} gcfr_event_type;

endpackage : gcfr_pkg

// ### hw/gcfr_regs.sv
// Command byte register bank with fault status and fault light
`timescale 1ns/100ps
`default_nettype none
`include "gcfr_cfg.svh"

module gcfr_regs (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire gcfr_pkg::gcfr_wr_type   wr_i,
	input  wire logic [2:0]          rd_addr_i,
	input  wire gcfr_pkg::gcfr_event_type evt_i,
	output logic [7:0]               rd_data_o,
	output gcfr_pkg::gcfr_motion_type motion_o,
	output logic                     fault_led_o
);
	import gcfr_pkg::*;

	// Whole bank state in one record
	typedef struct packed {
		// Reset, initialising, ready, release finished
		gcfr_mode_type mode;
		// Stored activation bit
		logic          act;
		// Stored go-to bit
		logic          goto_b;
		// Stored automatic release bit
		logic          atr;
		// Stored release direction bit
		logic          ard;
		// Direction frozen at release start
		logic          rel_dir;
		// Automatic release in progress
		logic          rel_run;
		// Last target position byte
		logic [7:0]    target;
		// Last speed byte
		logic [7:0]    speed;
		// Last force byte
		logic [7:0]    force_lim;
		// Gripper fault nibble
		logic [3:0]    gflt;
		// Controller fault nibble
		logic [3:0]    kflt;
		// Sticky gripper overcurrent marker
		logic          grip_oc;
		// Go-to granted to the engine
		logic          goto_q;
		// Blink half period timer
		logic [23:0]   blink_cnt;
		// Blink phase
		logic          blink;
		// Registered read byte
		logic [7:0]    rd_data;
		// Registered fault light
		logic          led;
	} gcfr_state_type;

	// Present and next copies of the bank state
	// Only the state register writes st
	gcfr_state_type st;
	gcfr_state_type next_st;

	// Strobe aimed at the command byte
	logic       wr_cmd;
	// Write data
	logic [7:0] wd;
	// Activation bit, newly written or held
	logic       act_w;
	// Go-to bit, newly written or held
	logic       goto_w;
	// Release bit, newly written or held
	logic       atr_w;
	// Any action besides activation requested
	logic       action_req;
	// Present code calls for a blinking light
	logic       major;
	// Present code calls for a steady light
	logic       minor;
	// Status byte zero
	logic [7:0] status0;
	// Mode field of status byte zero
	logic [1:0] sta;

	// Decode of the command byte write
	// A write in this cycle overrides the stored bits, so
	// mode and fault logic act on the new command at once
	always_comb begin
		// Incoming byte
		wd     = wr_i.data;
		// Strobe aimed at byte zero
		wr_cmd = wr_i.wr && (wr_i.addr == `GCFR_CMD_OFS);
		// LSB-first bit fields
		// Activation, go-to and release, new or held
		act_w  = wr_cmd ? wd[`GCFR_ACT_BIT]  : st.act;
		goto_w = wr_cmd ? wd[`GCFR_GOTO_BIT] : st.goto_b;
		atr_w  = wr_cmd ? wd[`GCFR_ATR_BIT]  : st.atr;
	end

	// Next state of the whole bank
	// Starts from the present state, so any field that no
	// branch below touches holds its value
	always_comb begin
		next_st = st;
		// Any action beside activation
		action_req = goto_w || atr_w;

		// Reserved bits not stored
		// Bits one, two, six and seven fall away here
		if (wr_cmd) begin
			next_st.act    = wd[`GCFR_ACT_BIT];
			next_st.goto_b = wd[`GCFR_GOTO_BIT];
			next_st.atr    = wd[`GCFR_ATR_BIT];
			next_st.ard    = wd[`GCFR_ARD_BIT];
		end

		// Byte indices zero to five
		// Bytes one and two are reserved and ignored;
		// byte zero is taken above, six and seven fall out
		if (wr_i.wr) begin
			case (wr_i.addr)
				`GCFR_POS_OFS: begin
					next_st.target = wd;
				end
				`GCFR_SPEED_OFS: begin
					next_st.speed = wd;
				end
				// Current limit for the motion engine
				`GCFR_FORCE_OFS: begin
					next_st.force_lim = wd;
				end
				default: ;
			endcase
		end

		// Gripper mode sequence
		// Reset to init on activation, init to ready once
		// calibration is reported, ready to release finished
		// when an automatic release ends; release finished
		// is left only through a cleared activation
		case (st.mode)
			GCFR_RESET: begin
				if (act_w) begin
					next_st.mode = GCFR_INIT;
				end
			end
			GCFR_INIT: begin
				if (evt_i.init_done) begin
					next_st.mode = GCFR_READY;
				end
			end
			GCFR_READY: begin
				if (st.rel_run && evt_i.release_done) begin
					next_st.mode = GCFR_RELDONE;
				end
			end
			GCFR_RELDONE: begin
				// Held until activation is cleared
			end
			default: begin
				next_st.mode = GCFR_RESET;
			end
		endcase

		// Direction latched at release start
		// Taken from the same write when both bits arrive
		// together; later direction writes wait for the next
		// release
		if (!st.rel_run && atr_w && st.mode == GCFR_READY) begin
			next_st.rel_run = 1'b1;
			next_st.rel_dir = wr_cmd ? wd[`GCFR_ARD_BIT] : st.ard;
		end
		// Engine reports the mechanical limits reached
		if (st.rel_run && evt_i.release_done) begin
			next_st.rel_run = 1'b0;
		end

		// Clearing activate resets mode, release and marker
		// Mode, release and overcurrent marker return to
		// their reset values while activation is clear
		if (!act_w) begin
			next_st.mode    = GCFR_RESET;
			next_st.rel_run = 1'b0;
			next_st.grip_oc = 1'b0;
		end

		// Gripper overcurrent, sticky until activation is cleared or reset
		// After the clear, so a trip in the same cycle as a
		// cleared activation is kept
		if (evt_i.grip_overcur) begin
			next_st.grip_oc = 1'b1;
		end

		// Gripper fault code, most severe first
		// Worked out on the next state, so a code changes on
		// the same edge as the mode or release that causes it
		// Release done is major
		if (next_st.mode == GCFR_RELDONE) begin
			next_st.gflt = `GCFR_G_REL_DONE;
		end
		else if (next_st.rel_run) begin
			next_st.gflt = `GCFR_G_RELEASING;
		end else if (next_st.grip_oc) begin
			next_st.gflt = `GCFR_G_OVERCUR;
		end
		else if (action_req && !act_w) begin
			next_st.gflt = `GCFR_G_NOT_ACT;
		end else if (action_req && next_st.mode == GCFR_INIT) begin
			next_st.gflt = `GCFR_G_NOT_READY;
		end else begin
			next_st.gflt = `GCFR_G_NONE;
		end

		// Controller fault code, most severe first
		// Plain levels from the controller side, not stored
		// Controller major faults
		if (evt_i.estop) begin
			next_st.kflt = `GCFR_K_ESTOP;
		end else if (evt_i.ctrl_overcur) begin
			next_st.kflt = `GCFR_K_OVERCUR;
		end
		else if (evt_i.comm_wait) begin
			next_st.kflt = `GCFR_K_COMM_WAIT;
		end
		else if (evt_i.no_24v) begin
			next_st.kflt = `GCFR_K_NO_24V;
		end else if (evt_i.no_device) begin
			next_st.kflt = `GCFR_K_NO_DEV;
		end else begin
			next_st.kflt = `GCFR_K_NONE;
		end

		// Blink timer for major faults
		// Free running, so the light phase is arbitrary when
		// a major fault appears; the count wraps at the last
		// value of one half period
		if (st.blink_cnt == 24'((`GCFR_BLINK_CYC / 1000) - 1)) begin
			next_st.blink_cnt = 24'h000000;
			next_st.blink     = ~st.blink;
		end else begin
			next_st.blink_cnt = st.blink_cnt + 24'h000001;
		end

		// Fault light: blink for major, steady for minor
		// Built from the registered codes, so the light lags
		// the code by one cycle; warnings leave it dark
		// Gripper release finished blinks
		major = (st.gflt == `GCFR_G_REL_DONE) ||
			(st.kflt == `GCFR_K_ESTOP) || (st.kflt == `GCFR_K_OVERCUR);
		minor = (st.gflt == `GCFR_G_RELEASING) ||
			(st.gflt == `GCFR_G_OVERCUR) ||
			(st.kflt == `GCFR_K_COMM_WAIT);
		// Major outranks minor when both are present
		next_st.led = major ? st.blink : minor;

		// Go-to grant for the motion engine
		// Needs ready mode, the stored go-to bit, activation
		// and no release in progress; it follows the command
		// register by one cycle
		// Go-to refused unless ready
		next_st.goto_q = (st.mode == GCFR_READY) && st.goto_b &&
			!st.rel_run && st.act;

		// Status readback
		// Mode field: 01 initialising, 11 ready, else 00
		case (st.mode)
			GCFR_INIT: begin
				sta = 2'b01;
			end
			GCFR_READY: begin
				sta = 2'b11;
			end
			default: begin
				sta = 2'b00;
			end
		endcase
		// Activate echo in bit zero
		// Bit three is the go-to grant, bits five and four the
		// mode field; reserved and object bits read zero
		status0 = {2'b00, sta, st.goto_q, 2'b00, st.act};
		// Byte picked by the read index, registered once;
		// unimplemented bytes read zero
		case (rd_addr_i)
			`GCFR_CMD_OFS: begin
				next_st.rd_data = status0;
			end
			`GCFR_RSV_B_OFS: begin
				next_st.rd_data = {st.kflt, st.gflt};
			end
			`GCFR_POS_OFS: begin
				next_st.rd_data = st.target;
			end
			default: begin
				next_st.rd_data = `GCFR_BYTE_RST;
			end
		endcase
	end

	// State register
	// Asynchronous reset clears the whole record, so every
	// output but the force mask is low while reset is held
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs to the motion engine
	// Plain copies of the state record, except the force
	// mask, which follows the engine's start-zone flag
	always_comb begin
		motion_o.goto_en     = st.goto_q;
		motion_o.release_en  = st.rel_run;
		motion_o.release_dir = st.rel_dir;
		motion_o.target      = st.target;
		motion_o.speed       = st.speed;
		// Force code is the current limit
		motion_o.force_lim   = st.force_lim;
		motion_o.force_mask  = evt_i.near_start;
		// Status byte and fault light
		rd_data_o   = st.rd_data;
		fault_led_o = st.led;
	end

endmodule // gcfr_regs
`default_nettype wire

// ### dv/gcfr_regs_assertions.sv
// Port checks for the command and fault register block
`timescale 1ns/100ps
`default_nettype none
module gcfr_regs_chk (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire gcfr_pkg::gcfr_wr_type     wr_i,
	input wire logic [2:0]                rd_addr_i,
	input wire gcfr_pkg::gcfr_event_type  evt_i,
	input wire logic [7:0]                rd_data_o,
	input wire gcfr_pkg::gcfr_motion_type motion_o,
	input wire logic                      fault_led_o
);
	import gcfr_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_pos;
		wr_i.wr && wr_i.addr == 3'h3 |=> motion_o.target == $past(wr_i.data);
	endproperty
	a_pos: assert property (p_pos) else $error("target copy");
	property p_frc;
		wr_i.wr && wr_i.addr == 3'h5 |=> motion_o.force_lim == $past(wr_i.data);
	endproperty
	a_frc: assert property (p_frc) else $error("force copy");
	property p_mask;
		motion_o.force_mask == evt_i.near_start;
	endproperty
	a_mask: assert property (p_mask) else $error("force mask");
	property p_echo;
		rd_addr_i == 3'h3 |=> rd_data_o == $past(motion_o.target);
	endproperty
	a_echo: assert property (p_echo) else $error("target echo");
	property p_nogo;
		wr_i.wr && wr_i.addr == 3'h0 && !wr_i.data[0]
			|-> ##2 !motion_o.goto_en && !motion_o.release_en;
	endproperty
	a_nogo: assert property (p_nogo) else $error("action w/o act");
	property p_spd_nogo;
		wr_i.wr && wr_i.addr == 3'h4 && !motion_o.goto_en
			&& !$past(wr_i.wr && wr_i.addr == 3'h0) |=> !motion_o.goto_en;
	endproperty
	a_spd_nogo: assert property (p_spd_nogo) else $error("speed moved");
	property p_warn;
		rd_addr_i == 3'h2 ##1 rd_data_o[3:0] == 4'h0
			&& rd_data_o[7:4] inside {4'h0, 4'h4, 4'h5} |-> !fault_led_o;
	endproperty
	a_warn: assert property (p_warn) else $error("light on");
	property p_rel_first;
		motion_o.release_en |=> !motion_o.goto_en;
	endproperty
	a_rel_first: assert property (p_rel_first) else $error("goto in release");
	c_goto: cover property ($rose(motion_o.goto_en));
	c_rel: cover property ($rose(motion_o.release_en));
	c_led: cover property ($rose(fault_led_o));
endmodule // gcfr_regs_chk
`default_nettype wire

// ### dv/gcfr_engine_model.sv
// Motion engine stand-in: start zone and release completion
`timescale 1ns/100ps
`default_nettype none
module gcfr_engine_model (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire gcfr_pkg::gcfr_motion_type motion_i,
	output logic                           release_done_o,
	output logic                           near_start_o
);
	import gcfr_pkg::*;
	logic [3:0] rc;
	logic [3:0] gc;
	// Cycles spent releasing and moving, saturating
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rc <= 4'h0;
			gc <= 4'h0;
		end else begin
			rc <= motion_i.release_en ? rc + {3'h0, rc != 4'hf} : 4'h0;
			gc <= motion_i.goto_en ? gc + {3'h0, gc != 4'hf} : 4'h0;
		end
	end
	assign release_done_o = rc == 4'h8;
	assign near_start_o = motion_i.goto_en && gc < 4'h3;
endmodule // gcfr_engine_model
`default_nettype wire

// ### dv/gcfr_regs_tb.sv
// Self-checking bench for the command and fault register block
`timescale 1ns/100ps
`default_nettype none
`include "gcfr_cfg.svh"
module gcfr_regs_tb;
	import gcfr_pkg::*;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	gcfr_wr_type     wr = '0;
	logic [2:0]      ra = 3'h0;
	gcfr_event_type  ev = '0;
	gcfr_event_type  evt;
	gcfr_motion_type mo;
	logic [7:0]      rd;
	logic            led;
	wire logic       rdone;
	wire logic       near;
	int              fails = 0;
	int              check_count = 0;
	int              n;
	logic            led_seen;
	logic [7:0]      kc [5] = '{8'h90, 8'h50, 8'h40, 8'hc0, 8'he0};

	always #20 clk = ~clk;
	// Engine events merged into bench conditions
	always_comb begin
		evt = ev;
		evt.release_done = rdone;
		evt.near_start = near;
	end
	gcfr_regs dut_u (.clk_i(clk), .rst_i(rst), .wr_i(wr), .rd_addr_i(ra),
		.evt_i(evt), .rd_data_o(rd), .motion_o(mo), .fault_led_o(led));
	gcfr_engine_model eng_u (.clk_i(clk), .rst_i(rst), .motion_i(mo),
		.release_done_o(rdone), .near_start_o(near));

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic put(input logic [2:0] a, input logic [7:0] d);
		wr = '{1'b1, a, d};
		@(posedge clk);
		// Strobe dropped on the taking edge, once per step
		wr <= '0;
		#1;
	endtask
	task automatic get(input logic [2:0] a, input logic [7:0] e);
		ra = a;
		step(2);
		chk("status", e, rd);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		step(5);
		rst = 1'b0;
		for (int i = 0; i < 6; i++)
			get(3'(i), 8'h00);
		$display("reset test done");
		put(0, 8'h08);
		step(1);
		chk("goto", 8'h00, {7'h0, mo.goto_en});
		get(2, 8'h07);
		put(0, 8'h01);
		get(0, 8'h11);
		put(0, 8'h09);
		get(2, 8'h05);
		put(0, 8'h01);
		ev.init_done = 1'b1;
		step(1);
		ev.init_done = 1'b0;
		get(0, 8'h31);
		$display("activation test done");
		put(3, 8'hff);
		put(4, 8'h00);
		put(5, 8'h80);
		put(0, 8'h09);
		step(2);
		chk("goto", 8'h01, {7'h0, mo.goto_en});
		chk("mask", 8'h01, {7'h0, mo.force_mask});
		chk("target", 8'hff, mo.target);
		chk("speed", 8'h00, mo.speed);
		chk("force", 8'h80, mo.force_lim);
		get(3, 8'hff);
		put(4, 8'h7f);
		step(1);
		chk("speed", 8'h7f, mo.speed);
		put(1, 8'haa);
		put(2, 8'h55);
		put(0, 8'hcf);
		get(0, 8'h39);
		get(1, 8'h00);
		$display("motion test done");
		put(0, 8'h39);
		step(1);
		chk("release", 8'h01, {7'h0, mo.release_en});
		chk("goto", 8'h00, {7'h0, mo.goto_en});
		chk("dir", 8'h01, {7'h0, mo.release_dir});
		put(0, 8'h19);
		get(2, 8'h0b);
		chk("led", 8'h01, {7'h0, led});
		chk("dir", 8'h01, {7'h0, mo.release_dir});
		step(12);
		get(2, 8'h0f);
		led_seen = led;
		n = 0;
		while (led === led_seen && n < (`GCFR_BLINK_CYC / 1000) + 8) begin
			step(1);
			n++;
		end
		chk("blink", 8'h01, {7'h0, led !== led_seen});
		put(0, 8'h09);
		step(2);
		chk("goto", 8'h00, {7'h0, mo.goto_en});
		put(0, 8'h00);
		get(2, 8'h00);
		chk("led", 8'h00, {7'h0, led});
		$display("release test done");
		put(0, 8'h01);
		ev.grip_overcur = 1'b1;
		step(1);
		ev.grip_overcur = 1'b0;
		get(2, 8'h0e);
		chk("led", 8'h01, {7'h0, led});
		put(0, 8'h00);
		get(2, 8'h00);
		for (int i = 0; i < 5; i++) begin
			ev[5:1] = 5'h1 << i;
			get(2, kc[i]);
			if (i < 3)
				chk("led", {7'h0, i == 0}, {7'h0, led});
		end
		ev = '0;
		$display("fault code test done");
		tally_and_finish();
	end
endmodule // gcfr_regs_tb
`default_nettype wire
bind gcfr_regs gcfr_regs_chk chk_u (.clk_i, .rst_i, .wr_i, .rd_addr_i,
	.evt_i, .rd_data_o, .motion_o, .fault_led_o);
